// file: dv/dfs_fault_status_checker.sv
// dfs_fault_status_checker: port-level assertions for the data fault status block.
// assumes it is bound to dfs_fault_status, one core clock domain.
`timescale 1ns/1ps
`default_nettype none
module dfs_fault_status_checker #(
  parameter logic [31:0] HYP_TRANSLATION_CTRL_REG_MASK = dfs_pkg::HYP_TRANSLATION_CTRL_REG_WMASK
) (
  input wire logic                 core_clk_i,
  input wire logic                 arst_n_i,
  input wire dfs_pkg::dfs_fault_t  fault_i,
  input wire dfs_pkg::dfs_cp_req_t cp_req_i,
  input wire dfs_pkg::dfs_cp_rsp_t cp_rsp_o
);
  import dfs_pkg::*;
  logic        rq, df, ha, ht;
  logic [13:0] at;
  assign rq = cp_req_i.valid;
  assign at = {cp_req_i.opc1, cp_req_i.crn, cp_req_i.crm, cp_req_i.opc2};
  assign df = rq && at == {DATA_FAULT_STATUS_OPC1, DATA_FAULT_STATUS_CRN, DATA_FAULT_STATUS_CRM, DATA_FAULT_STATUS_OPC2};
  assign ha = rq && at == {HYP_AUX_CONFIG_REG_OPC1, HYP_AUX_CONFIG_REG_CRN, HYP_AUX_CONFIG_REG_CRM, HYP_AUX_CONFIG_REG_OPC2};
  assign ht = rq && at == {HYP_TRANSLATION_CTRL_REG_OPC1, HYP_TRANSLATION_CTRL_REG_CRN, HYP_TRANSLATION_CTRL_REG_CRM, HYP_TRANSLATION_CTRL_REG_OPC2};
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  a_rsp_on_req: assert property (rq |=> cp_rsp_o.valid)
    else $error("no response after request");
  a_rsp_only_req: assert property (!rq |=> !cp_rsp_o.valid)
    else $error("response without request");
  a_data_fault_status_decode: assert property (df |=> cp_rsp_o.hit)
    else $error("status register not decoded");
  a_pl0_refused: assert property (df && cp_req_i.priv == PRIV_PL0 |=>
    cp_rsp_o.undef && cp_rsp_o.rdata == 32'h0000_0000)
    else $error("lowest privilege not refused");
  a_pl1_allowed: assert property (df && cp_req_i.priv != PRIV_PL0 |=> !cp_rsp_o.undef)
    else $error("privileged access refused");
  a_reserved_zero: assert property (df && !cp_req_i.write |=>
    (cp_rsp_o.rdata & ~DATA_FAULT_STATUS_WMASK) == 32'h0000_0000)
    else $error("reserved status bits not zero");
  a_hyp_aux_config_reg_reads_zero: assert property (ha |=> cp_rsp_o.rdata == 32'h0000_0000)
    else $error("aux config register not zero");
  a_hyp_translation_ctrl_reg_bits_masked: assert property (ht |=>
    (cp_rsp_o.rdata & ~HYP_TRANSLATION_CTRL_REG_MASK) == 32'h0000_0000)
    else $error("translation control spare bits set");
  a_hyp_refused: assert property ((ha || ht) &&
    (cp_req_i.priv != PRIV_PL2 || cp_req_i.secure) |=> cp_rsp_o.undef)
    else $error("hyp register access not refused");
  a_miss_quiet: assert property (rq && !df && !ha && !ht |=>
    !cp_rsp_o.hit && !cp_rsp_o.undef)
    else $error("unmapped access answered");
  c_data_fault_status_read: cover property (df && !cp_req_i.write && cp_req_i.priv == PRIV_PL1);
  c_pl0_try: cover property (df && cp_req_i.priv == PRIV_PL0);
  c_async_fault: cover property (fault_i.valid && fault_i.kind == FK_ASYNC_EXT);
  c_hyp_translation_ctrl_reg_write: cover property (ht && cp_req_i.write);
endmodule // dfs_fault_status_checker
bind dfs_fault_status dfs_fault_status_checker #(.HYP_TRANSLATION_CTRL_REG_MASK(HYP_TRANSLATION_CTRL_REG_MASK)) u_chk (
  .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .fault_i(fault_i),
  .cp_req_i(cp_req_i), .cp_rsp_o(cp_rsp_o));
`default_nettype wire

// file: dv/dfs_fault_status_tb.sv
// dfs_fault_status_tb: directed bench for the data fault status block.
// assumes dfs_pkg, the design and its bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module dfs_fault_status_tb;
  import dfs_pkg::*;
  localparam logic [13:0] A_DF = {DATA_FAULT_STATUS_OPC1, DATA_FAULT_STATUS_CRN, DATA_FAULT_STATUS_CRM, DATA_FAULT_STATUS_OPC2};
  localparam logic [13:0] A_HA = {HYP_AUX_CONFIG_REG_OPC1, HYP_AUX_CONFIG_REG_CRN, HYP_AUX_CONFIG_REG_CRM, HYP_AUX_CONFIG_REG_OPC2};
  localparam logic [13:0] A_HT = {HYP_TRANSLATION_CTRL_REG_OPC1, HYP_TRANSLATION_CTRL_REG_CRN, HYP_TRANSLATION_CTRL_REG_CRM, HYP_TRANSLATION_CTRL_REG_OPC2};
  logic        core_clk, arst_n;
  dfs_fault_t  fault;
  dfs_cp_req_t req;
  dfs_cp_rsp_t rsp, got;
  int          fail_count = 0;
  int          check_count = 0;
  dfs_fault_status #(.HYP_TRANSLATION_CTRL_REG_MASK(HYP_TRANSLATION_CTRL_REG_WMASK)) uut (.core_clk_i(core_clk), .arst_n_i(arst_n),
    .fault_i(fault), .cp_req_i(req), .cp_rsp_o(rsp));
  // ----------------------------------------------------------------
  // drivers and comparison
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  function automatic logic [31:0] fl();
    return 32'({got.valid, got.hit, got.undef});
  endfunction
  // request held one cycle, response sampled once the taking edge has landed
  task automatic cp(input logic w, input logic [13:0] a, input logic s,
                    input logic [1:0] p, input logic [31:0] d);
    @(posedge core_clk);
    req <= {1'b1, w, a, s, p, d};
    @(posedge core_clk);
    req.valid <= 1'b0;
    #1 got = rsp;
  endtask
  task automatic flt(input dfs_kind_t k, input logic sl, cm, wr, sv, input logic [3:0] dm,
                     input logic s);
    @(posedge core_clk);
    fault <= {1'b1, k, sl, cm, wr, sv, dm, s};
    @(posedge core_clk);
    fault.valid <= 1'b0;
  endtask
  function automatic logic [31:0] exp_f(dfs_kind_t k, logic sl, cm, wr, sv, logic [3:0] dm);
    logic [4:0] c;
    logic       ext_abort_kind;
    case (k)
      FK_ALIGN:    c = 5'h01;
      FK_DEBUG:    c = 5'h02;
      FK_AFLAG:    c = sl ? 5'h06 : 5'h03;
      FK_ICMAINT:  c = 5'h04;
      FK_TRANS:    c = sl ? 5'h07 : 5'h05;
      FK_SYNC_EXT: c = 5'h08;
      FK_DOMAIN:   c = sl ? 5'h0b : 5'h09;
      FK_WALK_EXT: c = sl ? 5'h0e : 5'h0c;
      FK_PERM:     c = sl ? 5'h0f : 5'h0d;
      default:     c = 5'h16;
    endcase
    ext_abort_kind = sv && (k == FK_SYNC_EXT || k == FK_WALK_EXT || k == FK_ASYNC_EXT);
    return {18'h0_0000, cm && k != FK_ASYNC_EXT, ext_abort_kind, cm | wr, c[4], 2'b00, dm, c[3:0]};
  endfunction
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    for (int s = 0; s < 2; s++) begin
      cp(1'b0, A_DF, s[0], PRIV_PL1, 32'h0000_0000);
      chk(fl(), 32'h0000_0006);
      chk(got.rdata, DATA_FAULT_STATUS_RESET);
    end
  endtask
  task automatic t_codes();
    dfs_kind_t k;
    for (int i = 0; i < 20; i++) begin
      k = dfs_kind_t'(i >> 1);
      flt(k, i[0], i[1], i[2], i[1] ^ i[2], 4'(15 - i / 2), i[0]);
      cp(1'b0, A_DF, i[0], PRIV_PL1, 32'h0000_0000);
      chk(got.rdata, exp_f(k, i[0], i[1], i[2], i[1] ^ i[2], 4'(15 - i / 2)));
    end
  endtask
  task automatic t_bank();
    cp(1'b1, A_DF, 1'b1, PRIV_PL1, 32'hffff_ffff);
    cp(1'b1, A_DF, 1'b0, PRIV_PL2, 32'h0000_1234);
    cp(1'b0, A_DF, 1'b1, PRIV_PL1, 32'h0000_0000);
    chk(got.rdata, DATA_FAULT_STATUS_WMASK);
    cp(1'b0, A_DF, 1'b0, PRIV_PL1, 32'h0000_0000);
    chk(got.rdata, 32'h0000_1234 & DATA_FAULT_STATUS_WMASK);
  endtask
  task automatic t_priv();
    cp(1'b1, A_DF, 1'b0, PRIV_PL0, 32'h0000_00ff);
    chk(fl(), 32'h0000_0007);
    cp(1'b0, A_DF, 1'b0, PRIV_PL0, 32'h0000_0000);
    chk(got.rdata, 32'h0000_0000);
    cp(1'b0, A_DF, 1'b0, PRIV_PL2, 32'h0000_0000);
    chk(got.rdata, 32'h0000_1234 & DATA_FAULT_STATUS_WMASK);
  endtask
  // two faults on successive edges: only the later one may remain
  task automatic t_b2b();
    @(posedge core_clk);
    fault <= {1'b1, FK_DOMAIN, 1'b1, 1'b0, 1'b1, 1'b0, 4'h3, 1'b0};
    @(posedge core_clk);
    fault <= {1'b1, FK_ASYNC_EXT, 1'b0, 1'b1, 1'b0, 1'b1, 4'h9, 1'b0};
    @(posedge core_clk);
    fault.valid <= 1'b0;
    cp(1'b0, A_DF, 1'b0, PRIV_PL1, 32'h0000_0000);
    chk(got.rdata, exp_f(FK_ASYNC_EXT, 1'b0, 1'b1, 1'b0, 1'b1, 4'h9));
  endtask
  // fault and software write on one edge: the fault wins; a read beside a capture sees old data
  task automatic t_race();
    @(posedge core_clk);
    fault <= {1'b1, FK_ALIGN, 1'b0, 1'b0, 1'b1, 1'b0, 4'h5, 1'b1};
    req   <= {1'b1, 1'b1, A_DF, 1'b1, PRIV_PL1, 32'h0000_00f0};
    @(posedge core_clk);
    fault.valid <= 1'b0;
    req.valid   <= 1'b0;
    #1 got = rsp;
    chk(fl(), 32'h0000_0006);
    chk(got.rdata, 32'h0000_0000);
    cp(1'b0, A_DF, 1'b1, PRIV_PL1, 32'h0000_0000);
    chk(got.rdata, exp_f(FK_ALIGN, 1'b0, 1'b0, 1'b1, 1'b0, 4'h5));
    @(posedge core_clk);
    fault <= {1'b1, FK_DEBUG, 1'b0, 1'b0, 1'b0, 1'b0, 4'h2, 1'b1};
    req   <= {1'b1, 1'b0, A_DF, 1'b1, PRIV_PL1, 32'h0000_0000};
    @(posedge core_clk);
    fault.valid <= 1'b0;
    req.valid   <= 1'b0;
    #1 got = rsp;
    chk(got.rdata, exp_f(FK_ALIGN, 1'b0, 1'b0, 1'b1, 1'b0, 4'h5));
    cp(1'b0, A_DF, 1'b1, PRIV_PL1, 32'h0000_0000);
    chk(got.rdata, exp_f(FK_DEBUG, 1'b0, 1'b0, 1'b0, 1'b0, 4'h2));
  endtask
  task automatic t_hyp();
    cp(1'b1, A_HA, 1'b0, PRIV_PL2, 32'hffff_ffff);
    cp(1'b0, A_HA, 1'b0, PRIV_PL2, 32'h0000_0000);
    chk(got.rdata, HYP_AUX_CONFIG_REG_VALUE);
    cp(1'b1, A_HT, 1'b0, PRIV_PL2, 32'hffff_ffff);
    cp(1'b0, A_HT, 1'b0, PRIV_PL2, 32'h0000_0000);
    chk(got.rdata, HYP_TRANSLATION_CTRL_REG_WMASK);
    cp(1'b1, A_HT, 1'b1, PRIV_PL2, 32'h0000_0000);
    chk(fl(), 32'h0000_0007);
    cp(1'b1, A_HT, 1'b0, PRIV_PL1, 32'h0000_0000);
    chk(fl(), 32'h0000_0007);
    cp(1'b0, A_HT, 1'b0, PRIV_PL2, 32'h0000_0000);
    chk(got.rdata, HYP_TRANSLATION_CTRL_REG_WMASK);
    cp(1'b0, {DATA_FAULT_STATUS_OPC1, DATA_FAULT_STATUS_CRN, 4'h1, DATA_FAULT_STATUS_OPC2}, 1'b0, PRIV_PL1, 32'h0000_0000);
    chk(fl(), 32'h0000_0004);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    arst_n = 1'b0;
    fault = '0;
    req = '0;
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    t_reset();
    t_codes();
    t_bank();
    t_priv();
    t_b2b();
    t_race();
    t_hyp();
    tally_and_finish();
  end
  // whole run needs about 150 cycles
  initial begin
    repeat (2000) @(posedge core_clk);
    fail_count++;
    tally_and_finish();
  end
endmodule // dfs_fault_status_tb
`default_nettype wire

// file: verilog/dfs_fault_status.sv
// dfs_fault_status: data fault status capture, banked per security state, with the
// two hypervisor registers that sit beside it in coprocessor space.
// assumes fault reports and coprocessor requests are synchronous to core_clk_i.
//
// Overview of operation
// RL1 - cache-maintenance flag bit 13 set when a maintenance op caused a synchronous fault
// RL2 - external abort: bit 12 is 0 for decode error, 1 for slave error
// RL3 - non-external aborts report 0 in bit 12
// RL4 - bit 11 records read (0) or write (1) of the faulting access
// RL5 - faults from maintenance and address translation ops always report write
// RL6 - five-bit fault code: top bit at 10, lower four at 3 to 0
// RL7 - bits 7 to 4 hold the accessed domain, one of sixteen
// RL8 - domain may be unknown for permission faults; software must ignore it
// RL9 - only defined fault codes are ever produced
// RL10 - page permission fault is 0b01111, asynchronous external abort 0b10110
// RL11 - every data fault overwrites the register with its own status
// RL12 - separate secure and non-secure copies, selected by current state
// RL13 - register access only from privilege level one or higher
// RL14 - layout follows translation format; this block is short-descriptor only
// RL15 - hyp auxiliary configuration register unimplemented, reads unknown, write zero
// RL16 - hyp translation control implementation-defined bits read unknown, write zero
// RL17 - access via coprocessor transfer with opcode1 0, c5, c0, opcode2 0
// RL18 - bit 9 reads zero; bits 31 to 14 and 8 reserved, write zero
// RL19 - other codes follow the standard short-descriptor fault assignments
`timescale 1ns/1ps
`default_nettype none
module dfs_fault_status #(
  parameter logic [31:0] HYP_TRANSLATION_CTRL_REG_MASK = dfs_pkg::HYP_TRANSLATION_CTRL_REG_WMASK
) (
  input  wire logic                 core_clk_i,
  input  wire logic                 arst_n_i,
  input  wire dfs_pkg::dfs_fault_t  fault_i,
  input  wire dfs_pkg::dfs_cp_req_t cp_req_i,
  output dfs_pkg::dfs_cp_rsp_t      cp_rsp_o
);
  import dfs_pkg::*;

  // ----------------------------------------------------------------
  // fault code encoder
  // ----------------------------------------------------------------
  // every kind maps onto a listed code, so reserved encodings cannot appear
  function automatic logic [4:0] fs_encode(input dfs_kind_t kind, input logic lvl2);
    logic [4:0] code;
    code = FS_ALIGN;
    case (kind)
      FK_ALIGN:     code = FS_ALIGN;                            // [RL19]
      FK_DEBUG:     code = FS_DEBUG;                            // [RL19]
      FK_AFLAG:     code = lvl2 ? FS_AFLAG_PAGE : FS_AFLAG_SECT; // [RL19]
      FK_ICMAINT:   code = FS_ICMAINT;                          // [RL19]
      FK_TRANS:     code = lvl2 ? FS_TRANS_PAGE : FS_TRANS_SECT; // [RL19]
      FK_SYNC_EXT:  code = FS_SYNC_EXT;                         // [RL19]
      FK_DOMAIN:    code = lvl2 ? FS_DOM_PAGE : FS_DOM_SECT;    // [RL19]
      FK_WALK_EXT:  code = lvl2 ? FS_WALK_EXT_L2 : FS_WALK_EXT_L1; // [RL19]
      FK_PERM:      code = lvl2 ? FS_PERM_PAGE : FS_PERM_SECT;  // [RL10]
      FK_ASYNC_EXT: code = FS_ASYNC_EXT;                        // [RL10]
      default:      code = FS_ALIGN;                            // [RL9]
    endcase
    return code;
  endfunction

  // ----------------------------------------------------------------
  // capture value
  // ----------------------------------------------------------------
  logic [4:0]  cap_code;
  logic        cap_is_ext;
  logic        cap_is_sync;
  logic [31:0] cap_val;

  always_comb begin
    cap_code    = fs_encode(fault_i.kind, fault_i.second_level);
    cap_is_ext  = (fault_i.kind == FK_SYNC_EXT) || (fault_i.kind == FK_WALK_EXT) ||
                  (fault_i.kind == FK_ASYNC_EXT);
    cap_is_sync = (fault_i.kind != FK_ASYNC_EXT);
    cap_val     = DATA_FAULT_STATUS_RESET;
    cap_val[CM_BIT]  = cap_is_sync && fault_i.cache_maint;     // [RL1]
    cap_val[EXT_BIT] = cap_is_ext ? fault_i.slverr : 1'b0;     // [RL2] [RL3]
    cap_val[WNR_BIT] = fault_i.cache_maint || fault_i.is_write; // [RL4] [RL5]
    cap_val[FS4_BIT] = cap_code[4];                             // [RL6]
    cap_val[RAZ_BIT] = 1'b0;                                    // [RL18]
    // permission faults still record the domain; its value is not promised
    cap_val[DOM_HI:DOM_LO] = fault_i.domain;                    // [RL7] [RL8]
    cap_val[FS_LO_HI:0]    = cap_code[3:0];                     // [RL6] [RL14]
  end

  // ----------------------------------------------------------------
  // coprocessor decode
  // ----------------------------------------------------------------
  logic hit_data_fault_status;
  logic hit_hyp_aux_config_reg;
  logic hit_hyp_translation_ctrl_reg;
  logic allow_data_fault_status;
  logic allow_hyp;
  logic acc_hit;
  logic acc_ok;

  always_comb begin
    hit_data_fault_status = (cp_req_i.opc1 == DATA_FAULT_STATUS_OPC1) && (cp_req_i.crn == DATA_FAULT_STATUS_CRN) &&
               (cp_req_i.crm == DATA_FAULT_STATUS_CRM) && (cp_req_i.opc2 == DATA_FAULT_STATUS_OPC2); // [RL17]
    hit_hyp_aux_config_reg = (cp_req_i.opc1 == HYP_AUX_CONFIG_REG_OPC1) && (cp_req_i.crn == HYP_AUX_CONFIG_REG_CRN) &&
               (cp_req_i.crm == HYP_AUX_CONFIG_REG_CRM) && (cp_req_i.opc2 == HYP_AUX_CONFIG_REG_OPC2);
    hit_hyp_translation_ctrl_reg = (cp_req_i.opc1 == HYP_TRANSLATION_CTRL_REG_OPC1) && (cp_req_i.crn == HYP_TRANSLATION_CTRL_REG_CRN) &&
               (cp_req_i.crm == HYP_TRANSLATION_CTRL_REG_CRM) && (cp_req_i.opc2 == HYP_TRANSLATION_CTRL_REG_OPC2);
    allow_data_fault_status = (cp_req_i.priv >= PRIV_PL1);                   // [RL13]
    // hyp registers are reached from hyp mode only, and only as non-secure
    allow_hyp  = (cp_req_i.priv == PRIV_PL2) && !cp_req_i.secure;
    acc_hit    = hit_data_fault_status || hit_hyp_aux_config_reg || hit_hyp_translation_ctrl_reg;
    acc_ok     = (hit_data_fault_status && allow_data_fault_status) || ((hit_hyp_aux_config_reg || hit_hyp_translation_ctrl_reg) && allow_hyp);
  end

  // ----------------------------------------------------------------
  // banked fault status copies, index 0 non-secure, 1 secure
  // ----------------------------------------------------------------
  logic [1:0]  bank_cap;
  logic [1:0]  bank_wr;
  logic [31:0] bank_val [2];

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_bank
      assign bank_cap[gi] = fault_i.valid && (fault_i.secure == 1'(gi));       // [RL12]
      assign bank_wr[gi]  = cp_req_i.valid && cp_req_i.write && hit_data_fault_status &&
                            allow_data_fault_status && (cp_req_i.secure == 1'(gi));         // [RL12]
      dfs_fsr_bank #(
        .RESET_VAL (DATA_FAULT_STATUS_RESET),
        .WR_MASK   (DATA_FAULT_STATUS_WMASK)
      ) u_bank (
        .core_clk_i (core_clk_i),
        .arst_n_i   (arst_n_i),
        .cap_en_i   (bank_cap[gi]),
        .cap_val_i  (cap_val),
        .wr_en_i    (bank_wr[gi]),
        .wr_val_i   (cp_req_i.wdata),
        .value_o    (bank_val[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // hyp translation control: only architected bits are held
  // ----------------------------------------------------------------
  logic [31:0] hyp_translation_ctrl_reg_reg;
  logic [31:0] hyp_translation_ctrl_reg_next;

  always_comb begin
    hyp_translation_ctrl_reg_next = hyp_translation_ctrl_reg_reg;
    if (cp_req_i.valid && cp_req_i.write && hit_hyp_translation_ctrl_reg && allow_hyp) begin
      hyp_translation_ctrl_reg_next = cp_req_i.wdata & HYP_TRANSLATION_CTRL_REG_MASK; // [RL16]
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hyp_translation_ctrl_reg_reg <= HYP_TRANSLATION_CTRL_REG_RESET;
    end else begin
      hyp_translation_ctrl_reg_reg <= hyp_translation_ctrl_reg_next;
    end
  end

  // ----------------------------------------------------------------
  // response, one cycle after the request
  // ----------------------------------------------------------------
  dfs_cp_rsp_t rsp_reg;
  dfs_cp_rsp_t rsp_next;

  always_comb begin
    rsp_next       = '0;
    rsp_next.valid = cp_req_i.valid;
    rsp_next.hit   = cp_req_i.valid && acc_hit;
    // an access without privilege is refused and reads as zero
    rsp_next.undef = cp_req_i.valid && acc_hit && !acc_ok;       // [RL13]
    if (cp_req_i.valid && !cp_req_i.write && acc_ok) begin
      if (hit_data_fault_status) begin
        rsp_next.rdata = bank_val[cp_req_i.secure];              // [RL12] [RL17]
      end else if (hit_hyp_aux_config_reg) begin
        rsp_next.rdata = HYP_AUX_CONFIG_REG_VALUE;                             // [RL15]
      end else begin
        rsp_next.rdata = hyp_translation_ctrl_reg_reg & HYP_TRANSLATION_CTRL_REG_MASK;                   // [RL16]
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rsp_reg <= '0;
    end else begin
      rsp_reg <= rsp_next;
    end
  end

  assign cp_rsp_o = rsp_reg;
endmodule // dfs_fault_status
`default_nettype wire

// file: verilog/dfs_fsr_bank.sv
// dfs_fsr_bank: one banked copy of the data fault status register.
// assumes capture and software write are already qualified by the caller.
`timescale 1ns/1ps
`default_nettype none
module dfs_fsr_bank #(
  parameter logic [31:0] RESET_VAL = dfs_pkg::DATA_FAULT_STATUS_RESET,
  parameter logic [31:0] WR_MASK   = dfs_pkg::DATA_FAULT_STATUS_WMASK
) (
  input  wire logic        core_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        cap_en_i,
  input  wire logic [31:0] cap_val_i,
  input  wire logic        wr_en_i,
  input  wire logic [31:0] wr_val_i,
  output logic      [31:0] value_o
);
  import dfs_pkg::*;

  logic [31:0] value_reg;
  logic [31:0] value_next;

  // ----------------------------------------------------------------
  // next value
  // ----------------------------------------------------------------
  // a fault in the same cycle as a software write wins: the event is never lost
  always_comb begin
    value_next = value_reg;
    if (cap_en_i) begin
      value_next = cap_val_i & WR_MASK; // [RL11]
    end else if (wr_en_i) begin
      value_next = wr_val_i & WR_MASK; // [RL18]
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      value_reg <= RESET_VAL;
    end else begin
      value_reg <= value_next;
    end
  end

  assign value_o = value_reg;
endmodule // dfs_fsr_bank
`default_nettype wire

// file: verilog/dfs_pkg.sv
// dfs_pkg: constants, field layout and carrier types of the data fault status block.
// assumes one core clock domain; fault reports and coprocessor requests are synchronous.
package dfs_pkg;

  // ----------------------------------------------------------------
  // register layout
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned CM_BIT     = 13;
  localparam int unsigned EXT_BIT    = 12;
  localparam int unsigned WNR_BIT    = 11;
  localparam int unsigned FS4_BIT    = 10;
  localparam int unsigned RAZ_BIT    = 9;
  localparam int unsigned DOM_HI     = 7;
  localparam int unsigned DOM_LO     = 4;
  localparam int unsigned FS_LO_HI   = 3;
  localparam logic [31:0] DATA_FAULT_STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] DATA_FAULT_STATUS_WMASK = 32'h0000_3cff;
  localparam logic [31:0] HYP_TRANSLATION_CTRL_REG_RESET = 32'h0000_0000;
  localparam logic [31:0] HYP_TRANSLATION_CTRL_REG_WMASK = 32'h0000_3f07;
  localparam logic [31:0] HYP_AUX_CONFIG_REG_VALUE = 32'h0000_0000;

  // ----------------------------------------------------------------
  // coprocessor coordinates: opcode1, crn, crm, opcode2
  // ----------------------------------------------------------------
  localparam logic [2:0] DATA_FAULT_STATUS_OPC1 = 3'h0;
  localparam logic [3:0] DATA_FAULT_STATUS_CRN  = 4'h5;
  localparam logic [3:0] DATA_FAULT_STATUS_CRM  = 4'h0;
  localparam logic [2:0] DATA_FAULT_STATUS_OPC2 = 3'h0;
  localparam logic [2:0] HYP_AUX_CONFIG_REG_OPC1 = 3'h4;
  localparam logic [3:0] HYP_AUX_CONFIG_REG_CRN  = 4'h1;
  localparam logic [3:0] HYP_AUX_CONFIG_REG_CRM  = 4'h1;
  localparam logic [2:0] HYP_AUX_CONFIG_REG_OPC2 = 3'h7;
  localparam logic [2:0] HYP_TRANSLATION_CTRL_REG_OPC1 = 3'h4;
  localparam logic [3:0] HYP_TRANSLATION_CTRL_REG_CRN  = 4'h2;
  localparam logic [3:0] HYP_TRANSLATION_CTRL_REG_CRM  = 4'h0;
  localparam logic [2:0] HYP_TRANSLATION_CTRL_REG_OPC2 = 3'h2;

  // ----------------------------------------------------------------
  // privilege levels
  // ----------------------------------------------------------------
  localparam logic [1:0] PRIV_PL0 = 2'h0;
  localparam logic [1:0] PRIV_PL1 = 2'h1;
  localparam logic [1:0] PRIV_PL2 = 2'h2;

  // ----------------------------------------------------------------
  // fault status codes, short-descriptor format
  // ----------------------------------------------------------------
  localparam logic [4:0] FS_ALIGN       = 5'h01;
  localparam logic [4:0] FS_DEBUG       = 5'h02;
  localparam logic [4:0] FS_AFLAG_SECT  = 5'h03;
  localparam logic [4:0] FS_ICMAINT     = 5'h04;
  localparam logic [4:0] FS_TRANS_SECT  = 5'h05;
  localparam logic [4:0] FS_AFLAG_PAGE  = 5'h06;
  localparam logic [4:0] FS_TRANS_PAGE  = 5'h07;
  localparam logic [4:0] FS_SYNC_EXT    = 5'h08;
  localparam logic [4:0] FS_DOM_SECT    = 5'h09;
  localparam logic [4:0] FS_DOM_PAGE    = 5'h0b;
  localparam logic [4:0] FS_WALK_EXT_L1 = 5'h0c;
  localparam logic [4:0] FS_PERM_SECT   = 5'h0d;
  localparam logic [4:0] FS_WALK_EXT_L2 = 5'h0e;
  localparam logic [4:0] FS_PERM_PAGE   = 5'h0f;
  localparam logic [4:0] FS_ASYNC_EXT   = 5'h16;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    FK_ALIGN    = 4'h0,
    FK_DEBUG    = 4'h1,
    FK_AFLAG    = 4'h2,
    FK_ICMAINT  = 4'h3,
    FK_TRANS    = 4'h4,
    FK_SYNC_EXT = 4'h5,
    FK_DOMAIN   = 4'h6,
    FK_WALK_EXT = 4'h7,
    FK_PERM     = 4'h8,
    FK_ASYNC_EXT = 4'h9
  } dfs_kind_t;

  typedef struct packed {
    logic       valid;
    dfs_kind_t  kind;
    logic       second_level;
    logic       cache_maint;
    logic       is_write;
    logic       slverr;
    logic [3:0] domain;
    logic       secure;
  } dfs_fault_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [2:0]  opc1;
    logic [3:0]  crn;
    logic [3:0]  crm;
    logic [2:0]  opc2;
    logic        secure;
    logic [1:0]  priv;
    logic [31:0] wdata;
  } dfs_cp_req_t;

  typedef struct packed {
    logic        valid;
    logic        hit;
    logic        undef;
    logic [31:0] rdata;
  } dfs_cp_rsp_t;

endpackage
